// ===== src/cgw_pkg.sv
// Package for the gateway FIFO event and frame conversion block.
// Assumes a 32-bit APB slave and one 100 MHz clock domain.
`default_nettype none
package cgw_pkg;
    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] CGW_GLOBAL_CONTROL_REG = 8'h00;
    localparam logic [7:0] CGW_GLOBAL_ERROR_FLAGS_REG = 8'h04;
    localparam logic [7:0] CGW_FD_CONFIG_REG = 8'h08;
    localparam logic [7:0] CGW_FIFO_CONFIG_REG = 8'h0C;
    localparam logic [7:0] CGW_FIFO_EXT_CONFIG_REG = 8'h10;
    localparam logic [7:0] CGW_FIFO_STATUS_REG = 8'h14;
    localparam logic [7:0] CGW_CHANNEL_HISTORY_STATUS_REG = 8'h18;
    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int CGW_GC_MSG_LOST_IE = 0;
    localparam int CGW_GC_DLC_IE = 1;
    localparam int CGW_GC_PAYLOAD_IE = 2;
    localparam int CGW_GC_QOW_IE = 3;
    localparam int CGW_GC_QLOST_IE = 4;
    localparam int CGW_GC_GWOW_IE = 5;
    localparam int CGW_GC_HIST_IE = 6;
    localparam int CGW_GE_HIST = 0;
    localparam int CGW_GE_DLC = 1;
    localparam int CGW_GE_PAYLOAD = 2;
    localparam int CGW_GE_QOW = 3;
    localparam int CGW_GE_QLOST = 4;
    localparam int CGW_GE_GWOW = 5;
    localparam int CGW_FD_MODE = 0;
    localparam int CGW_FD_CONV_EN = 1;
    localparam int CGW_FD_FMT = 2;
    localparam int CGW_FD_BRS = 3;
    localparam int CGW_FC_USE_EN = 0;
    localparam int CGW_FC_COND = 1;
    localparam int CGW_FC_TXIE = 2;
    localparam int CGW_FS_TX_FLAG = 0;
    localparam int CGW_FS_LOST_FLAG = 1;
    localparam int CGW_FS_OF_FLAG = 2;
    localparam int CGW_FS_EMPTY = 3;
    localparam int CGW_FS_FULL = 4;
    // ------------------------------------------------------------
    // Reset values and DLC limits
    // ------------------------------------------------------------
    localparam logic [31:0] CGW_REG_RESET = 32'h0000_0000;
    localparam logic [3:0] CGW_DLC_LIMIT = 4'h9;
    localparam logic [3:0] CGW_DLC_CLAMP = 4'h8;
    // Frame carried through the gateway buffer
    typedef struct packed {
        logic [28:0] id;
        logic ide;
        logic fdf;
        logic brs;
        logic [3:0] dlc;
        logic [63:0] data;
    } cgw_frame_t;
    localparam int CGW_FRAME_W = $bits(cgw_frame_t);
endpackage
`default_nettype wire

// ===== src/cgw_fifo.sv
// Frame buffer module: kept in cgw_core.sv beside the logic that uses it.
// This file holds no code.

// ===== src/cgw_core.sv
// Gateway FIFO event logic and classical/FD frame conversion.
// Assumes an APB master, a receive path feeding frames and a
// transmit engine that takes frames and reports completion.
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Selector one: flag after every transmitted message
// - One-frame interrupt only while its enable set
// - Lost message raises global error when enabled
// - One lost-enable bit covers all FIFOs
// - Lost flag sticky until software writes zero
// - Global error merges individually enabled sources
// - History status follows all channel lost flags
// - Format replacement only in FD mode
// - Conversion enable bit gates conversion
// - FDF and BRS come from config bits
// - DLC nine or more clamps to eight when converting to FD format
// - Format select zero classical, one FD
// - Disabling FIFO keeps pending flags
module cgw_core
    import cgw_pkg::*;
#(
    parameter int DEPTH = 16,
    parameter int CHANNELS = 2
) (
    input wire logic i_sys_clk,
    input wire logic i_rstn,
    input wire logic i_ce,
    // APB slave
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    // Received frames into the gateway FIFO
    input wire logic i_rx_valid,
    output logic o_rx_ready,
    input wire cgw_pkg::cgw_frame_t i_rx_frame,
    // Converted frames to the transmit engine
    output logic o_tx_valid,
    input wire logic i_tx_ready,
    output cgw_pkg::cgw_frame_t o_tx_frame,
    input wire logic i_tx_done,
    // Error event pulses from other parts of the controller
    input wire logic i_dlc_err,
    input wire logic i_payload_ow,
    input wire logic i_queue_ow,
    input wire logic i_queue_lost,
    input wire logic i_gw_ow,
    input wire logic [CHANNELS-1:0] i_hist_lost,
    // Interrupt requests
    output logic o_fifo_tx_irq,
    output logic o_one_frame_irq,
    output logic o_global_err_irq
);
    import cgw_pkg::*;
    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [6:0] gctl, next_gctl;           // Global control enables
    logic [3:0] fd_config_reg, next_fd_config_reg;         // FD config bits
    logic [2:0] fcfg, next_fcfg;           // FIFO config
    logic ecfg, next_ecfg;                 // One-frame enable
    logic tx_flag, next_tx_flag;           // FIFO transmit flag
    logic lost_flag, next_lost_flag;       // Message lost flag
    logic of_flag, next_of_flag;           // One-frame flag
    logic [5:1] gerr, next_gerr;           // Global error flags
    logic [CHANNELS-1:0] hist, next_hist;  // Channel history lost
    logic [31:0] next_prdata;
    logic next_pready, next_pslverr;
    logic fifo_tx_irq, one_frame_irq, global_err_irq;
    logic [CHANNELS-1:0] hist_s1, hist_s2;
    // ------------------------------------------------------------
    // FIFO
    // ------------------------------------------------------------
    logic rx_ready, rx_take, tx_take, fifo_out_valid;
    logic [CGW_FRAME_W-1:0] fifo_out;
    logic [$clog2(DEPTH):0] level;
    logic lost_evt, sent_evt, empty_evt, flush;
    cgw_frame_t raw, conv, next_tx_frame, tx_frame;
    logic tx_valid, next_tx_valid, awaiting, next_awaiting;
    logic wr_acc, rd_acc;
    assign flush = !fcfg[CGW_FC_USE_EN];
    // Frames are only dropped, never back-pressured upstream, so a
    // full buffer counts as a lost message
    assign lost_evt = i_rx_valid && fcfg[CGW_FC_USE_EN] && !rx_ready;
    assign rx_take = i_rx_valid && fcfg[CGW_FC_USE_EN];
    assign tx_take = fifo_out_valid && !tx_valid && !awaiting;
    cgw_fifo #(.WIDTH(CGW_FRAME_W), .DEPTH(DEPTH)) u_fifo (
        .i_sys_clk(i_sys_clk),
        .i_rstn(i_rstn),
        .i_ce(i_ce),
        .i_flush(flush),
        .i_in_valid(rx_take),
        .o_in_ready(rx_ready),
        .i_in_data(i_rx_frame),
        .o_out_valid(fifo_out_valid),
        .i_out_ready(tx_take),
        .o_out_data(fifo_out),
        .o_level(level)
    );
    // ------------------------------------------------------------
    // Frame conversion
    // ------------------------------------------------------------
    always_comb begin
        raw = cgw_frame_t'(fifo_out);
        conv = raw;
        if (fd_config_reg[CGW_FD_MODE] && fd_config_reg[CGW_FD_CONV_EN]) begin
            conv.fdf = fd_config_reg[CGW_FD_FMT];
            conv.brs = fd_config_reg[CGW_FD_FMT] & fd_config_reg[CGW_FD_BRS];
            if (fd_config_reg[CGW_FD_FMT] && raw.dlc >= CGW_DLC_LIMIT) begin
                conv.dlc = CGW_DLC_CLAMP;
            end
        end
    end
    // ------------------------------------------------------------
    // Transmit hand-off: one frame in flight until done
    // ------------------------------------------------------------
    always_comb begin
        next_tx_valid = tx_valid;
        next_tx_frame = tx_frame;
        next_awaiting = awaiting;
        if (tx_take) begin
            next_tx_valid = 1'b1;
            next_tx_frame = conv;
        end else if (tx_valid && i_tx_ready) begin
            next_tx_valid = 1'b0;
            next_awaiting = 1'b1;
        end
        if (awaiting && i_tx_done) begin
            next_awaiting = 1'b0;
        end
    end
    assign sent_evt = awaiting && i_tx_done;
    // Emptiness by transmission: last frame done and nothing queued
    assign empty_evt = sent_evt && (level == '0);
    // ------------------------------------------------------------
    // APB decode and flag logic
    // ------------------------------------------------------------
    assign wr_acc = i_psel && i_penable && i_pwrite && !o_pready;
    assign rd_acc = i_psel && i_penable && !i_pwrite && !o_pready;
    always_comb begin
        next_gctl = gctl;
        next_fd_config_reg = fd_config_reg;
        next_fcfg = fcfg;
        next_ecfg = ecfg;
        next_tx_flag = tx_flag;
        next_lost_flag = lost_flag;
        next_of_flag = of_flag;
        next_gerr = gerr;
        next_hist = hist;
        next_prdata = 32'h0000_0000;
        next_pready = i_psel && i_penable && !o_pready;
        next_pslverr = 1'b0;
        // Software clears by writing zero; ones leave flags alone
        if (wr_acc) begin
            case (i_paddr)
                CGW_GLOBAL_CONTROL_REG: next_gctl = i_pwdata[6:0];
                CGW_FD_CONFIG_REG: next_fd_config_reg = i_pwdata[3:0];
                CGW_FIFO_CONFIG_REG: next_fcfg = i_pwdata[2:0];
                CGW_FIFO_EXT_CONFIG_REG: next_ecfg = i_pwdata[0];
                CGW_FIFO_STATUS_REG: begin
                    next_tx_flag = tx_flag & i_pwdata[CGW_FS_TX_FLAG];
                    next_lost_flag = lost_flag & i_pwdata[CGW_FS_LOST_FLAG];
                    next_of_flag = of_flag & i_pwdata[CGW_FS_OF_FLAG];
                end
                CGW_GLOBAL_ERROR_FLAGS_REG: next_gerr = gerr & i_pwdata[5:1];
                CGW_CHANNEL_HISTORY_STATUS_REG: next_hist = hist & i_pwdata[CHANNELS-1:0];
                default: next_pslverr = 1'b1;
            endcase
        end
        if (rd_acc) begin
            case (i_paddr)
                CGW_GLOBAL_CONTROL_REG: next_prdata = {25'h0, gctl};
                CGW_GLOBAL_ERROR_FLAGS_REG: next_prdata = {26'h0, gerr, |hist};
                CGW_FD_CONFIG_REG: next_prdata = {28'h0, fd_config_reg};
                CGW_FIFO_CONFIG_REG: next_prdata = {29'h0, fcfg};
                CGW_FIFO_EXT_CONFIG_REG: next_prdata = {31'h0, ecfg};
                CGW_FIFO_STATUS_REG: next_prdata = {27'h0, !rx_ready, level == '0,
                    of_flag, lost_flag, tx_flag};
                CGW_CHANNEL_HISTORY_STATUS_REG: next_prdata = 32'(hist);
                default: next_pslverr = 1'b1;
            endcase
        end
        // Hardware set wins over a same-cycle clear; disabling the
        // FIFO never clears a flag
        if (fcfg[CGW_FC_COND] ? sent_evt : empty_evt) next_tx_flag = 1'b1;
        if (sent_evt) next_of_flag = 1'b1;
        if (lost_evt) next_lost_flag = 1'b1;
        if (i_dlc_err) next_gerr[CGW_GE_DLC] = 1'b1;
        if (i_payload_ow) next_gerr[CGW_GE_PAYLOAD] = 1'b1;
        if (i_queue_ow) next_gerr[CGW_GE_QOW] = 1'b1;
        if (i_queue_lost) next_gerr[CGW_GE_QLOST] = 1'b1;
        if (i_gw_ow) next_gerr[CGW_GE_GWOW] = 1'b1;
        next_hist = next_hist | hist_s2;
    end
    // ------------------------------------------------------------
    // Interrupt outputs, withdrawn by flag clears or by clearing their enables
    // ------------------------------------------------------------
    always_comb begin
        fifo_tx_irq = next_tx_flag && next_fcfg[CGW_FC_TXIE];
        one_frame_irq = next_of_flag && next_ecfg;
        global_err_irq = (next_lost_flag && next_gctl[CGW_GC_MSG_LOST_IE])
            || (|next_hist && next_gctl[CGW_GC_HIST_IE])
            || (|(next_gerr & next_gctl[5:1]));
    end
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            gctl <= '0;
            fd_config_reg <= '0;
            fcfg <= '0;
            ecfg <= 1'b0;
            tx_flag <= 1'b0;
            lost_flag <= 1'b0;
            of_flag <= 1'b0;
            gerr <= '0;
            hist <= '0;
            hist_s1 <= '0;
            hist_s2 <= '0;
            tx_valid <= 1'b0;
            tx_frame <= '0;
            awaiting <= 1'b0;
            o_prdata <= CGW_REG_RESET;
            o_pready <= 1'b0;
            o_pslverr <= 1'b0;
            o_fifo_tx_irq <= 1'b0;
            o_one_frame_irq <= 1'b0;
            o_global_err_irq <= 1'b0;
        end else if (i_ce) begin
            gctl <= next_gctl;
            fd_config_reg <= next_fd_config_reg;
            fcfg <= next_fcfg;
            ecfg <= next_ecfg;
            tx_flag <= next_tx_flag;
            lost_flag <= next_lost_flag;
            of_flag <= next_of_flag;
            gerr <= next_gerr;
            hist <= next_hist;
            // Channel history pulses come from other logic; synchronise
            hist_s1 <= i_hist_lost;
            hist_s2 <= hist_s1;
            tx_valid <= next_tx_valid;
            tx_frame <= next_tx_frame;
            awaiting <= next_awaiting;
            o_prdata <= next_prdata;
            o_pready <= next_pready;
            o_pslverr <= next_pslverr;
            o_fifo_tx_irq <= fifo_tx_irq;
            o_one_frame_irq <= one_frame_irq;
            o_global_err_irq <= global_err_irq;
        end
    end
    assign o_tx_valid = tx_valid;
    assign o_tx_frame = tx_frame;
    assign o_rx_ready = rx_ready;
endmodule
// ------------------------------------------------------------
// Frame buffer: flip-flop FIFO, valid and ready on both sides
// ------------------------------------------------------------
module cgw_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input wire logic i_sys_clk,
    input wire logic i_rstn,
    input wire logic i_ce,
    input wire logic i_flush,
    input wire logic i_in_valid,
    output logic o_in_ready,
    input wire logic [WIDTH-1:0] i_in_data,
    output logic o_out_valid,
    input wire logic i_out_ready,
    output logic [WIDTH-1:0] o_out_data,
    output logic [$clog2(DEPTH):0] o_level
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] rd_ptr, wr_ptr, next_rd_ptr, next_wr_ptr;
    logic [AW:0] cnt, next_cnt;
    logic push, pop, in_ready_q; // Ready is registered so the top port comes from a flop
    // ------------------------------------------------------------
    // Pointer and count update
    // ------------------------------------------------------------
    always_comb begin
        push = i_in_valid && (cnt != (AW+1)'(DEPTH));
        pop = i_out_ready && (cnt != '0);
        next_rd_ptr = rd_ptr;
        next_wr_ptr = wr_ptr;
        next_cnt = cnt;
        if (i_flush) begin
            // Flush empties without touching storage
            next_rd_ptr = '0;
            next_wr_ptr = '0;
            next_cnt = '0;
        end else begin
            if (push) begin
                next_wr_ptr = (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + AW'(1);
            end
            if (pop) begin
                next_rd_ptr = (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + AW'(1);
            end
            next_cnt = cnt + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            rd_ptr <= '0;
            wr_ptr <= '0;
            cnt <= '0;
            in_ready_q <= 1'b1;
        end else if (i_ce) begin
            rd_ptr <= next_rd_ptr;
            wr_ptr <= next_wr_ptr;
            cnt <= next_cnt;
            in_ready_q <= (next_cnt != (AW+1)'(DEPTH));
        end
    end
    // Storage has no reset, only written on push
    always_ff @(posedge i_sys_clk) begin
        if (i_ce && push && !i_flush) begin
            mem[wr_ptr] <= i_in_data;
        end
    end
    assign o_in_ready = in_ready_q;
    assign o_out_valid = (cnt != '0);
    assign o_out_data = mem[rd_ptr];
    assign o_level = cnt;
endmodule
`default_nettype wire

// ===== tb/cgw_core_props.sv
// Concurrent checks on the gateway event block, seen from its top ports.
// Assumes APB with one wait state and a single 100 MHz clock domain.
`timescale 1ns/1ps
`default_nettype none
module cgw_core_props
    import cgw_pkg::*;
#(
    parameter int CHANNELS = 2
) (
    input wire logic i_sys_clk,
    input wire logic i_rstn,
    input wire logic i_ce,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic [31:0] o_prdata,
    input wire logic o_pready,
    input wire logic o_pslverr,
    input wire logic i_rx_valid,
    input wire logic o_rx_ready,
    input wire cgw_pkg::cgw_frame_t i_rx_frame,
    input wire logic o_tx_valid,
    input wire logic i_tx_ready,
    input wire cgw_pkg::cgw_frame_t o_tx_frame,
    input wire logic i_tx_done,
    input wire logic i_dlc_err,
    input wire logic i_payload_ow,
    input wire logic i_queue_ow,
    input wire logic i_queue_lost,
    input wire logic i_gw_ow,
    input wire logic [CHANNELS-1:0] i_hist_lost,
    input wire logic o_fifo_tx_irq,
    input wire logic o_one_frame_irq,
    input wire logic o_global_err_irq
);
    // ----------------------------------------
    // Shadow copies of the control fields
    // ----------------------------------------
    logic [7:0] gc, fd, fc, ext; // Taken at the same edge the block applies writes
    logic wr; // Completed write
    logic sw_wr; // Any write in progress may legally drop a request
    logic conv; // Conversion really active
    assign wr = i_psel && i_penable && i_pwrite && !o_pready;
    assign sw_wr = i_psel && i_pwrite;
    assign conv = fd[CGW_FD_MODE] && fd[CGW_FD_CONV_EN];
    // Shadow registers follow every completed write
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            {gc, fd, fc, ext} <= '0;
        end else if (wr) begin
            case (i_paddr)
                CGW_GLOBAL_CONTROL_REG: gc <= i_pwdata[7:0];
                CGW_FD_CONFIG_REG: fd <= i_pwdata[7:0];
                CGW_FIFO_CONFIG_REG: fc <= i_pwdata[7:0];
                CGW_FIFO_EXT_CONFIG_REG: ext <= i_pwdata[7:0];
                default: ;
            endcase
        end
    end
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_rstn);
    // Enabled error event from any of the five pulse sources
    sequence err_src;
        |({i_gw_ow, i_queue_lost, i_queue_ow, i_payload_ow, i_dlc_err} & gc[5:1]);
    endsequence
    // Frame offered while the buffer is full
    sequence lost_ev;
        i_rx_valid && !o_rx_ready && fc[CGW_FC_USE_EN] && gc[CGW_GC_MSG_LOST_IE];
    endsequence
    pready_bound_a: assert property ($rose(i_penable) && i_psel |-> ##[0:2] o_pready) else $error("pready late");
    pready_pulse_a: assert property (o_pready |=> !o_pready) else $error("pready held");
    slverr_pair_a: assert property (o_pslverr |-> o_pready) else $error("pslverr alone");
    tx_hold_a: assert property (o_tx_valid && !i_tx_ready |=> o_tx_valid && $stable(o_tx_frame))
        else $error("tx frame dropped");
    fd_format_a: assert property (o_tx_valid && conv && fd[CGW_FD_FMT] |->
        o_tx_frame.fdf && o_tx_frame.brs == fd[CGW_FD_BRS] && o_tx_frame.dlc <= CGW_DLC_CLAMP)
        else $error("fd rewrite wrong");
    classic_format_a: assert property (o_tx_valid && conv && !fd[CGW_FD_FMT] |->
        !o_tx_frame.fdf && !o_tx_frame.brs) else $error("classic rewrite wrong");
    tx_irq_set_a: assert property (i_tx_done && fc[CGW_FC_COND] && fc[CGW_FC_TXIE] |=> o_fifo_tx_irq)
        else $error("tx irq missing");
    one_frame_gate_a: assert property (o_one_frame_irq |-> ext[0] || $past(ext[0]))
        else $error("one frame irq ungated");
    err_raise_a: assert property (err_src |-> ##[1:2] o_global_err_irq) else $error("error irq missing");
    lost_raise_a: assert property (lost_ev |-> ##[1:2] o_global_err_irq) else $error("lost irq missing");
    err_sticky_a: assert property (o_global_err_irq && !sw_wr |=> o_global_err_irq)
        else $error("error irq dropped");
    tx_sticky_a: assert property (o_fifo_tx_irq && !sw_wr |=> o_fifo_tx_irq)
        else $error("tx irq dropped");
endmodule
bind cgw_core cgw_core_props #(.CHANNELS(CHANNELS)) i_cgw_core_props (.*);
`default_nettype wire

// ===== tb/cgw_tx_node.sv
// Far-side transmit node: takes frames and reports them sent.
// Assumes the block holds a frame valid until it is accepted.
`timescale 1ns/1ps
`default_nettype none
module cgw_tx_node
    import cgw_pkg::*;
(
    input wire logic i_sys_clk,
    input wire logic i_rstn,
    input wire logic i_stall,
    input wire logic [3:0] i_delay,
    input wire logic i_valid,
    output logic o_ready,
    input wire cgw_pkg::cgw_frame_t i_frame,
    output logic o_done,
    output cgw_pkg::cgw_frame_t o_last,
    output logic [7:0] o_count
);
    logic busy; // A frame is on the bus
    logic [3:0] wait_cnt; // Bus time left, loaded from i_delay on accept
    // Accept, hold for the bus time, then pulse completion once
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            {o_ready, o_done, busy, wait_cnt, o_last, o_count} <= '0;
        end else begin
            o_done <= 1'b0;
            o_ready <= 1'b0;
            if (o_ready && i_valid) begin
                busy <= 1'b1;
                wait_cnt <= i_delay;
                o_last <= i_frame;
            end else if (busy && wait_cnt == 4'h0) begin
                busy <= 1'b0;
                o_done <= 1'b1;
                o_count <= o_count + 8'h01;
            end else if (busy) begin
                wait_cnt <= wait_cnt - 4'h1;
            end else if (i_valid && !i_stall && !o_ready) begin
                o_ready <= 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// ===== tb/cgw_core_test.sv
// Bench for the gateway event block: APB tasks plus frame traffic.
// Assumes cgw_tx_node stands in for the bus side of the transmit path.
`timescale 1ns/1ps
`default_nettype none
module cgw_core_test;
    import cgw_pkg::*;
    localparam logic [7:0] ST = CGW_FIFO_STATUS_REG;
    localparam logic [7:0] GE = CGW_GLOBAL_ERROR_FLAGS_REG;
    logic sys_clk, rstn, psel, penable, pwrite, rx_valid, stall, pready, pslverr, rx_ready, e;
    logic tx_valid, tx_ready, tx_done, tx_irq, of_irq, err_irq;
    logic [7:0] paddr, tx_count;
    logic [31:0] pwdata, prdata, q;
    logic [4:0] ev; // Error event pulses
    logic [3:0] delay;
    logic [1:0] hist;
    cgw_frame_t rx_frame, tx_frame, last;
    int fail_count, cmp_count;
    cgw_core i_cgw_core (.i_sys_clk(sys_clk), .i_rstn(rstn), .i_ce(1'b1), .i_psel(psel), .i_penable(penable),
        .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
        .o_pslverr(pslverr), .i_rx_valid(rx_valid), .o_rx_ready(rx_ready), .i_rx_frame(rx_frame),
        .o_tx_valid(tx_valid), .i_tx_ready(tx_ready), .o_tx_frame(tx_frame), .i_tx_done(tx_done),
        .i_dlc_err(ev[0]), .i_payload_ow(ev[1]), .i_queue_ow(ev[2]), .i_queue_lost(ev[3]), .i_gw_ow(ev[4]),
        .i_hist_lost(hist), .o_fifo_tx_irq(tx_irq), .o_one_frame_irq(of_irq), .o_global_err_irq(err_irq));
    cgw_tx_node i_cgw_tx_node (.i_sys_clk(sys_clk), .i_rstn(rstn), .i_stall(stall), .i_delay(delay),
        .i_valid(tx_valid), .o_ready(tx_ready), .i_frame(tx_frame), .o_done(tx_done), .o_last(last),
        .o_count(tx_count));
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    // Watchdog: the whole run needs a few hundred cycles
    initial begin
        repeat (20000) @(posedge sys_clk);
        fail_count++;
        summarize();
    end
    task automatic summarize;
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic chk(input string s, input logic [31:0] x, input logic [31:0] g);
        cmp_count++;
        if (g !== x) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", s, x, g);
        end
    endtask
    // One APB transfer, then an idle edge so effects have landed
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge sys_clk);
        penable <= 1'b1;
        do begin
            @(posedge sys_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        q = prdata;
        e = pslverr;
        {psel, penable} <= 2'b00;
        @(posedge sys_clk);
        chk("pready", 32'h1, {31'h0, pready | (n < 20)});
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0);
        chk($sformatf("reg %h", a), x, q);
    endtask
    // Offer one frame; valid stays up for back-to-back offers
    task automatic send(input logic [3:0] dlc, input logic fdf);
        rx_frame <= {29'h0000123, 1'b0, fdf, 1'b0, dlc, 64'h0123_4567_89AB_CDEF};
        rx_valid <= 1'b1;
        @(posedge sys_clk);
    endtask
    task automatic wait_tx(input logic [7:0] k);
        for (int n = 0; n < 300 && tx_count < k; n++) @(posedge sys_clk);
        repeat (2) @(posedge sys_clk);
    endtask
    task automatic conv(input logic [31:0] f, input logic [3:0] dlc, input logic fdf, input logic [7:0] k,
        input logic [31:0] x);
        wr(CGW_FD_CONFIG_REG, f);
        send(dlc, fdf);
        rx_valid <= 1'b0;
        wait_tx(k);
        chk("fdf brs dlc", x, {26'h0, last[69:64]});
    endtask
    initial begin
        {psel, penable, pwrite, rx_valid, stall, ev, hist, paddr, pwdata, rx_frame, delay} = '0;
        {rstn, fail_count, cmp_count} = '0;
        repeat (20) @(posedge sys_clk);
        rstn <= 1'b1;
        @(posedge sys_clk);
        for (int a = 0; a < 7; a++) rd(8'(a * 4), (a == 5) ? 32'h8 : 32'h0);
        apb(1'b0, 8'h1C, 32'h0);
        chk("pslverr", 32'h1, {31'h0, e});
        wr(CGW_FIFO_CONFIG_REG, 32'h7);
        wr(CGW_FIFO_EXT_CONFIG_REG, 32'h1);
        conv(32'hF, 4'hA, 1'b0, 8'h1, 32'h38);
        chk("irqs", 32'h3, {30'h0, tx_irq, of_irq});
        rd(ST, 32'hD);
        wr(CGW_FIFO_EXT_CONFIG_REG, 32'h0);
        chk("irqs", 32'h2, {30'h0, tx_irq, of_irq});
        wr(CGW_FIFO_CONFIG_REG, 32'h0);
        rd(ST, 32'hD);
        wr(ST, 32'h0);
        rd(ST, 32'h8);
        wr(CGW_FIFO_CONFIG_REG, 32'h7);
        conv(32'h3, 4'h5, 1'b1, 8'h2, 32'h05);
        conv(32'h6, 4'hA, 1'b0, 8'h3, 32'h0A);
        conv(32'hD, 4'h9, 1'b0, 8'h4, 32'h09);
        conv(32'h7, 4'h9, 1'b0, 8'h5, 32'h28);
        wr(ST, 32'h0);
        wr(CGW_FIFO_CONFIG_REG, 32'h5);
        delay <= 4'hF;
        send(4'h1, 1'b0);
        send(4'h2, 1'b0);
        rx_valid <= 1'b0;
        wait_tx(8'h6);
        chk("tx irq", 32'h0, {31'h0, tx_irq});
        wait_tx(8'h7);
        chk("tx irq", 32'h1, {31'h0, tx_irq});
        wr(ST, 32'h0);
        wr(CGW_GLOBAL_CONTROL_REG, 32'h1);
        stall <= 1'b1;
        for (int i = 0; i < 20 && rx_ready; i++) send(4'h3, 1'b0);
        send(4'h3, 1'b0);
        rx_valid <= 1'b0;
        repeat (2) @(posedge sys_clk);
        chk("lost irq", 32'h1, {31'h0, err_irq});
        chk("rx ready", 32'h0, {31'h0, rx_ready});
        rd(ST, 32'h12);
        wr(ST, 32'h0);
        chk("lost irq", 32'h0, {31'h0, err_irq});
        {stall, delay} <= '0;
        for (int n = 0; n < 1000 && (tx_valid || !tx_irq); n++) @(posedge sys_clk);
        chk("drain irq", 32'h1, {31'h0, tx_irq});
        for (int i = 0; i < 5; i++) begin
            wr(CGW_GLOBAL_CONTROL_REG, 32'h2 << i);
            ev <= 5'h01 << i;
            @(posedge sys_clk);
            ev <= 5'h00;
            repeat (2) @(posedge sys_clk);
            chk("source irq", 32'h1, {31'h0, err_irq});
            rd(GE, 32'h2 << i);
            wr(GE, 32'h0);
            chk("source irq", 32'h0, {31'h0, err_irq});
        end
        wr(CGW_GLOBAL_CONTROL_REG, 32'h40);
        hist <= 2'b10;
        repeat (5) @(posedge sys_clk);
        hist <= 2'b00;
        chk("history irq", 32'h1, {31'h0, err_irq});
        rd(GE, 32'h1);
        rd(CGW_CHANNEL_HISTORY_STATUS_REG, 32'h2);
        wr(CGW_CHANNEL_HISTORY_STATUS_REG, 32'h0);
        rd(GE, 32'h0);
        summarize();
    end
endmodule
`default_nettype wire
